// File: src/port_a_pin_control.sv
// Summary of operation
// R01 - Direction 0 drives the latch bit; analog selection leaves output alone.
// R02 - Direction 1 shows pin level, but analog-selected pins read zero; pin four ignores analog_select[4] and still reads its level.
// R03 - After reset pin four is a digital input.
// R04 - After reset pins zero to three and five are analog inputs.
// R05 - Routed comparator one result drives pin four over the latch.
// R06 - Routed comparator two result drives pin five over the latch.
// R07 - Reference output on pin two disables its driver and input.
// R08 - Any analog use of pin two disables its digital input.
// R09 - Pin six is general I/O only in the three I/O oscillator modes.
// R10 - Clock-out modes drive the quarter-rate cycle clock on pin six.
// R11 - Oscillator modes using pin seven disable its digital paths.
// R12 - Pins six and seven read zero in all registers when not I/O, except the pin six driver bit of the status register in clock-out modes.
// R13 - Latch register reads and writes the stored latch, not pins.
// R14 - Oscillator, clock-out and reference output ignore the direction bit.
// R15 - Pin-level reads give pins; writes update the latch.
// R16 - Direction bit 1 tristates the driver.
// R17 - Alternate function selections arrive as static control inputs.
// R18 - Pin reads pass a synchroniser before software sees them.
`timescale 1ns/1ps
`default_nettype none
module port_a_pin_control
    import port_a_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    input wire logic [5:0] analog_select,
    input wire logic reference_low_select,
    input wire logic comparator_one_route,
    input wire logic comparator_two_route,
    input wire logic comparator_one_result,
    input wire logic comparator_two_result,
    input wire logic comparator_reference_output,
    input wire logic [2:0] osc_mode,
    output logic [7:0] timer_zero_clock_input
);

    logic [7:0] output_latch_r;
    logic [7:0] pin_direction_r;
    logic [7:0] pin_sampled;
    logic cycle_clock;
    logic [7:0] digital_in_en;
    logic [7:0] io_mask;
    logic pin_two_analog;
    logic [7:0] pin_level_view;
    logic [7:0] out_nxt;
    logic [7:0] oe_nxt;
    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_r;
    logic [31:0] prdata_nxt;
    logic addr_hit;
    logic wr_en;
    osc_mode_t mode;
    bus_state_t bus_state;

    // R17 static control inputs
    assign mode = osc_mode_t'(osc_mode);

    // ****************************************************************
    // Helper units
    // ****************************************************************
    // R18 pin synchroniser
    pin_sync #(
        .WIDTH(8)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_raw(pin_in),
        .pin_stable(pin_sampled)
    );

    cycle_clock_gen u_cycle (
        .clock(clock),
        .sys_rst(sys_rst),
        .cycle_clock(cycle_clock)
    );

    // ****************************************************************
    // Pin availability
    // ****************************************************************
    // R09 R11 oscillator pin gating
    always_comb
    begin
        io_mask = 8'hFF;
        io_mask[PIN_CLK_OUT] = pin_six_free(mode);
        io_mask[PIN_OSC_IN] = pin_seven_free(mode);
    end

    // R07 R08 analog uses of pin two
    assign pin_two_analog = analog_select[2] || reference_low_select
        || comparator_reference_output;

    // R02 R08 digital input enables
    always_comb
    begin
        digital_in_en = io_mask;
        digital_in_en[3:0] = digital_in_en[3:0] & ~analog_select[3:0];
        digital_in_en[5] = digital_in_en[5] & ~analog_select[5];
        // R08 any analog use of pin two
        if (pin_two_analog)
        begin
            digital_in_en[PIN_REF_OUT] = 1'b0;
        end
    end

    // R02 R12 R15 pin-level view
    assign pin_level_view = pin_sampled & digital_in_en;

    // ****************************************************************
    // Timer clock input
    // ****************************************************************
    // Timer clock input sees the synchronised pin four level.
    assign timer_zero_clock_input = {7'h00, pin_sampled[PIN_CMP_ONE]};

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    always_comb
    begin
        // R01 latch drives by default
        out_nxt = output_latch_r;
        // R05 comparator one override
        if (comparator_one_route && !pin_direction_r[PIN_CMP_ONE])
        begin
            out_nxt[PIN_CMP_ONE] = comparator_one_result;
        end
        // R06 comparator two override
        if (comparator_two_route && !pin_direction_r[PIN_CMP_TWO])
        begin
            out_nxt[PIN_CMP_TWO] = comparator_two_result;
        end
        // R10 cycle clock value
        if (pin_six_clock(mode))
        begin
            out_nxt[PIN_CLK_OUT] = cycle_clock;
        end
    end

    always_comb
    begin
        // R01 R16 direction zero drives
        oe_nxt = ~pin_direction_r & io_mask;
        // R07 R14 reference output kills driver
        if (comparator_reference_output)
        begin
            oe_nxt[PIN_REF_OUT] = 1'b0;
        end
        // R10 R14 cycle clock output
        if (pin_six_clock(mode))
        begin
            oe_nxt[PIN_CLK_OUT] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_out_r <= 8'h00;
        end
        else
        begin
            pin_out_r <= out_nxt;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_oe_r <= 8'h00;
        end
        else
        begin
            pin_oe_r <= oe_nxt;
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_state <= BUS_IDLE;
        end
        else
        begin
            case (bus_state)
                BUS_IDLE:
                begin
                    if (psel && !penable)
                    begin
                        bus_state <= BUS_SETUP;
                    end
                end
                BUS_SETUP:
                begin
                    bus_state <= BUS_ACCESS;
                end
                default:
                begin
                    bus_state <= (psel && !penable) ? BUS_SETUP : BUS_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    typedef enum logic [2:0]
    {
        SEL_NONE = 3'h0,
        SEL_PIN_LEVEL = 3'h1,
        SEL_LATCH = 3'h2,
        SEL_DIRECTION = 3'h3,
        SEL_STATUS = 3'h4
    } reg_sel_t;

    function automatic reg_sel_t decode_addr(input logic [11:0] a);
        reg_sel_t s;
        if (a == OFF_PIN_LEVEL)
        begin
            s = SEL_PIN_LEVEL;
        end
        else if (a == OFF_LATCH)
        begin
            s = SEL_LATCH;
        end
        else if (a == OFF_DIRECTION)
        begin
            s = SEL_DIRECTION;
        end
        else if (a == OFF_STATUS)
        begin
            s = SEL_STATUS;
        end
        else
        begin
            s = SEL_NONE;
        end
        return s;
    endfunction

    reg_sel_t reg_sel;

    assign reg_sel = decode_addr(paddr);

    // ****************************************************************
    // Handshake
    // ****************************************************************
    assign addr_hit = (reg_sel != SEL_NONE);
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_hit;
    // Writes take effect once, at the access edge that follows a setup edge.
    assign wr_en = psel && penable && pwrite && pstrb[0] && (bus_state == BUS_SETUP);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // R15 R13 latch write path
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            output_latch_r <= RST_LATCH;
        end
        else if (wr_en && ((reg_sel == SEL_PIN_LEVEL) || (reg_sel == SEL_LATCH)))
        begin
            output_latch_r <= pwdata[7:0];
        end
    end

    // R03 R04 direction resets to inputs
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_direction_r <= RST_DIRECTION;
        end
        else if (wr_en && (reg_sel == SEL_DIRECTION))
        begin
            pin_direction_r <= pwdata[7:0];
        end
    end

    // ****************************************************************
    // Register readback
    // ****************************************************************
    always_comb
    begin
        prdata_nxt = 32'h0000_0000;
        if (reg_sel == SEL_PIN_LEVEL)
        begin
            prdata_nxt[7:0] = pin_level_view;
        end
        // R13 R12 latch readback masked
        else if (reg_sel == SEL_LATCH)
        begin
            prdata_nxt[7:0] = output_latch_r & io_mask;
        end
        // R12 direction readback masked
        else if (reg_sel == SEL_DIRECTION)
        begin
            prdata_nxt[7:0] = pin_direction_r & io_mask;
        end
        else if (reg_sel == SEL_STATUS)
        begin
            prdata_nxt[7:0] = digital_in_en;
            prdata_nxt[15:8] = pin_oe_r;
        end
    end

    // ****************************************************************
    // Read data register
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= prdata_nxt;
        end
    end

endmodule
`default_nettype wire

// File: src/port_a_pkg.sv
package port_a_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] OFF_PIN_LEVEL = 12'h000;
    localparam logic [11:0] OFF_LATCH = 12'h004;
    localparam logic [11:0] OFF_DIRECTION = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hFF;

    // ****************************************************************
    // Pin positions
    // ****************************************************************
    localparam int PIN_REF_OUT = 2;
    localparam int PIN_CMP_ONE = 4;
    localparam int PIN_CMP_TWO = 5;
    localparam int PIN_CLK_OUT = 6;
    localparam int PIN_OSC_IN = 7;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CYCLE_CLOCK_DIV = 4;
    localparam int CYCLE_HALF = CYCLE_CLOCK_DIV / 2;

    // ****************************************************************
    // Oscillator modes
    // ****************************************************************
    typedef enum logic [2:0]
    {
        OSC_CRYSTAL = 3'h0,
        OSC_RC_CLOCK_OUT = 3'h1,
        OSC_RC_WITH_IO = 3'h2,
        OSC_INTERNAL_CLOCK_OUT = 3'h3,
        OSC_INTERNAL_TWO_IO = 3'h4,
        OSC_EXTERNAL_CLOCK_OUT = 3'h5,
        OSC_EXTERNAL_CLOCK_WITH_IO = 3'h6
    } osc_mode_t;

    // APB access states.
    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b00,
        BUS_SETUP = 2'b01,
        BUS_ACCESS = 2'b11
    } bus_state_t;

    function automatic logic pin_six_free(input osc_mode_t m);
        pin_six_free = (m == OSC_RC_WITH_IO) || (m == OSC_INTERNAL_TWO_IO)
            || (m == OSC_EXTERNAL_CLOCK_WITH_IO);
    endfunction

    function automatic logic pin_six_clock(input osc_mode_t m);
        pin_six_clock = (m == OSC_RC_CLOCK_OUT) || (m == OSC_INTERNAL_CLOCK_OUT)
            || (m == OSC_EXTERNAL_CLOCK_OUT);
    endfunction

    function automatic logic pin_seven_free(input osc_mode_t m);
        pin_seven_free = (m == OSC_INTERNAL_CLOCK_OUT) || (m == OSC_INTERNAL_TWO_IO);
    endfunction

endpackage

// File: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import port_a_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] pin_stable
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // ****************************************************************
    // Three flops; a change counts once stages two and three agree
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end
        else
        begin
            stage1_r <= pin_raw;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_stable <= '0;
        end
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2_r[i] == stage3_r[i])
                begin
                    pin_stable[i] <= stage3_r[i];
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: src/cycle_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_clock_gen
    import port_a_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    output logic cycle_clock
);

    logic [1:0] count_r;

    // ****************************************************************
    // Divide the clock by four
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_r <= 2'h0;
            cycle_clock <= 1'b0;
        end
        else
        begin
            if (count_r == 2'(CYCLE_HALF - 1))
            begin
                count_r <= 2'h0;
                cycle_clock <= ~cycle_clock;
            end
            else
            begin
                count_r <= count_r + 2'h1;
            end
        end
    end

endmodule
`default_nettype wire

// File: bench/port_a_properties.sv
`timescale 1ns/1ps
`default_nettype none
module port_a_checker
    import port_a_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic comparator_one_route,
    input wire logic comparator_one_result,
    input wire logic comparator_reference_output,
    input wire logic [2:0] osc_mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    logic acc;
    logic wr;
    logic ckm;
    logic io7;
    assign acc = psel && penable;
    assign wr = acc && pwrite && pstrb[0];
    assign ckm = osc_mode inside {3'h1, 3'h3, 3'h5};
    assign io7 = osc_mode inside {3'h3, 3'h4};
    zero_wait_a: assert property (pready == acc)
        else $error("ready does not follow access phase");
    bad_addr_a: assert property (acc |-> pslverr == (paddr > OFF_STATUS || paddr[1:0] != 2'h0))
        else $error("slave error does not match address");
    dir_write_a: assert property (wr && paddr == OFF_DIRECTION |-> ##2
        {pin_oe[3], pin_oe[1:0]} == ~{$past(pwdata[3], 2), $past(pwdata[1:0], 2)})
        else $error("direction write not applied to drivers");
    latch_drive_a: assert property (wr && paddr == OFF_LATCH ##2 pin_oe[0] |->
        pin_out[0] == $past(pwdata[0], 2)) else $error("latch value not driven");
    ref_out_a: assert property (comparator_reference_output [*2] |-> !pin_oe[2])
        else $error("pin two driven while reference out");
    cmp_one_a: assert property (comparator_one_route ##1 comparator_one_route && pin_oe[4] |->
        pin_out[4] == $past(comparator_one_result)) else $error("comparator one not driven");
    pin_seven_a: assert property ((!io7) [*2] |-> !pin_oe[7])
        else $error("pin seven driven in oscillator mode");
    clock_out_a: assert property (ckm && $past(ckm, 5) |-> pin_oe[6] &&
        pin_out[6] == $past(pin_out[6], 4) && pin_out[6] != $past(pin_out[6], 2))
        else $error("cycle clock output wrong");
endmodule
bind port_a_pin_control port_a_checker chk_i (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
    .comparator_one_route(comparator_one_route), .comparator_one_result(comparator_one_result),
    .comparator_reference_output(comparator_reference_output), .osc_mode(osc_mode));
`default_nettype wire

// File: bench/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model
(
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    // A pin nobody drives is pulled high on the board.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import port_a_pkg::*;
;
    localparam logic [6:0] CLK_MODES = 7'h2A;
    localparam logic [6:0] IO6_MODES = 7'h54;
    localparam logic [6:0] IO7_MODES = 7'h18;
    logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic ref_low, r1, r2, c1, c2, cref;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] pin_in, pin_out, pin_oe, ext_en, ext_val, t0;
    logic [5:0] asel;
    logic [2:0] osc;
    int n_mismatch = 0;
    int total_checks = 0;
    port_a_pin_control dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .analog_select(asel), .reference_low_select(ref_low),
        .comparator_one_route(r1), .comparator_two_route(r2), .comparator_one_result(c1),
        .comparator_two_result(c2), .comparator_reference_output(cref), .osc_mode(osc),
        .timer_zero_clock_input(t0));
    board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));
    always #5 clock = ~clock;
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask
    task automatic t_reset;
        rd_chk(OFF_DIRECTION, 32'h0000_003F, "direction reset");
        rd_chk(OFF_LATCH, 32'h0000_0000, "latch reset");
        rd_chk(OFF_PIN_LEVEL, 32'h0000_0010, "pin level reset");
        rd_chk(OFF_STATUS, 32'h0000_0010, "status reset");
    endtask
    task automatic t_latch;
        wr(OFF_DIRECTION, 32'h0000_0000);
        wr(OFF_LATCH, 32'h0000_002B);
        rd_chk(OFF_LATCH, 32'h0000_002B, "latch read");
        chk("analog pin drive", 32'({pin_oe[5:0], pin_out[5:0]}), 32'h0000_0FEB);
        wr(OFF_PIN_LEVEL, 32'h0000_0014);
        rd_chk(OFF_LATCH, 32'h0000_0014, "pin level write");
        repeat (4) @(posedge clock);
        rd_chk(OFF_PIN_LEVEL, 32'h0000_0010, "driven pin read");
    endtask
    task automatic t_input;
        osc <= 3'h4;
        asel <= 6'h00;
        ext_val <= 8'hB5;
        wr(OFF_DIRECTION, 32'h0000_00FF);
        repeat (8) @(posedge clock);
        rd_chk(OFF_PIN_LEVEL, 32'h0000_00B5, "pin input");
        chk("timer input high", 32'(t0), 32'h1);
        ext_val <= 8'h4E;
        rd_chk(OFF_PIN_LEVEL, 32'h0000_00B5, "sync delay");
        ref_low <= 1'b1;
        repeat (8) @(posedge clock);
        rd_chk(OFF_PIN_LEVEL, 32'h0000_004A, "low reference");
        chk("timer input low", 32'(t0), 32'h0);
        ref_low <= 1'b0;
        cref <= 1'b1;
        asel <= 6'h02;
        wr(OFF_DIRECTION, 32'h0000_00FB);
        repeat (3) @(posedge clock);
        chk("reference drive", 32'(pin_oe[2]), 32'h0);
        rd_chk(OFF_PIN_LEVEL, 32'h0000_0048, "reference input");
    endtask
    task automatic t_cmp;
        cref <= 1'b0;
        asel <= 6'h00;
        ref_low <= 1'b0;
        wr(OFF_DIRECTION, 32'h0000_0000);
        wr(OFF_LATCH, 32'h0000_0000);
        r1 <= 1'b1;
        r2 <= 1'b1;
        c1 <= 1'b1;
        c2 <= 1'b1;
        repeat (3) @(posedge clock);
        chk("comparator drive", 32'(pin_out[5:4]), 32'h3);
        c1 <= 1'b0;
        repeat (3) @(posedge clock);
        chk("comparator two", 32'(pin_out[5:4]), 32'h2);
        r1 <= 1'b0;
        r2 <= 1'b0;
        repeat (3) @(posedge clock);
        chk("latch restored", 32'(pin_out[5:4]), 32'h0);
    endtask
    task automatic t_bus;
        rd_chk(12'h010, 32'h0, "unmapped read");
        chk("slave error", 32'(err), 32'h1);
        pstrb <= 4'h0;
        wr(OFF_LATCH, 32'h0000_00FF);
        pstrb <= 4'hF;
        rd_chk(OFF_LATCH, 32'h0, "masked write");
    endtask
    task automatic t_osc;
        for (int m = 0; m < 7; m++)
        begin
            osc <= m[2:0];
            wr(OFF_DIRECTION, 32'h0000_0040);
            wr(OFF_LATCH, 32'h0000_00C0);
            repeat (3) @(posedge clock);
            chk("clock out", 32'(pin_oe[6]), 32'(CLK_MODES[m]));
            chk("pin seven", 32'(pin_oe[7]), 32'(IO7_MODES[m]));
            rd_chk(OFF_LATCH, {24'h0, IO7_MODES[m], IO6_MODES[m], 6'h0}, "latch");
            rd_chk(OFF_DIRECTION, {24'h0, 1'b0, IO6_MODES[m], 6'h0}, "direction");
        end
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        end_sim;
    end
    initial
    begin
        clock = 1'b0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, ref_low, r1, r2, c1, c2, cref} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        asel = 6'h2F;
        osc = 3'h0;
        ext_en = 8'hFF;
        ext_val = 8'hFF;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset;
        t_latch;
        t_input;
        t_cmp;
        t_bus;
        t_osc;
        end_sim;
    end
endmodule
`default_nettype wire
